// ---- hdl/irsw_link.sv ----
// Purpose: Device end of the single-wire sensor read-out link.
// Assumes: Samples arrive from the converter as 14-bit words; the host clocks the wire.
// Notes:   The wire is shared; this end drives it while it owns a phase, and holds it low whenever idle.
module irsw_link (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // Sample input from the converter and filter.
    input  wire logic        sample_valid,
    input  wire logic [13:0] sample_value,
    output logic             sample_ready,
    // Shared link pin, split into its three signals.
    input  wire logic        shared_link_pin_in,
    output logic             shared_link_pin_out,
    output logic             shared_link_pin_oe,
    // Status.
    output logic             frame_busy
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and edge detection.
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_prev <= 1'b0;
        end else begin
            pin_meta <= shared_link_pin_in;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    wire pin_rise = pin_sync && !pin_prev;

    ////////////////////////////////////////////////////////////////////////////
    // Sample buffer between the converter and the serial stage.
    logic        fifo_valid;
    logic        fifo_take;
    logic [13:0] fifo_data;
    logic        fifo_in_ready;

    irsw_fifo #(
        .WIDTH (irsw_pkg::DATA_BITS),
        .DEPTH (irsw_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (sample_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (sample_value),
        .out_valid (fifo_valid),
        .out_ready (fifo_take),
        .out_data  (fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Serial stage state.
    irsw_pkg::irsw_state_t state;
    irsw_pkg::irsw_state_t next_state;
    logic [14:0]           shift;
    logic [3:0]            bit_cnt;
    logic [31:0]           timer;
    logic [31:0]           low_timer;
    logic                  fresh;

    localparam logic [31:0] SETUP_CYC = 32'(irsw_pkg::START_SETUP_CYC);
    localparam logic [31:0] REFR_CYC  = 32'(irsw_pkg::REFRESH_CYC);
    localparam logic [31:0] GUARD_CYC = 32'(irsw_pkg::END_GUARD_CYC);
    localparam logic [3:0]  LAST_BIT  = 4'(irsw_pkg::SAMPLE_BITS);

    localparam irsw_pkg::irsw_state_t IRSW_IDLE_S  = irsw_pkg::IRSW_IDLE;
    localparam irsw_pkg::irsw_state_t IRSW_START_S = irsw_pkg::IRSW_START;
    localparam irsw_pkg::irsw_state_t IRSW_SHIFT_S = irsw_pkg::IRSW_SHIFT;
    localparam irsw_pkg::irsw_state_t IRSW_END_S   = irsw_pkg::IRSW_END;

    // Head of the buffer, carried as one word.
    irsw_pkg::irsw_sample_t head;
    assign head = {fifo_valid, fifo_data};

    wire [14:0] load_word  = {1'b0, head.value};
    wire        setup_done = (timer >= SETUP_CYC);
    // A data 0 in bit 0 hides the host's closing pulse, so the frame ends on a guard.
    wire        end_done   = (timer >= GUARD_CYC);
    // The timer runs only while a timed state persists, so every entry starts at zero.
    wire        timed_hold = ((state == IRSW_START_S) || (state == IRSW_END_S)) && (next_state == state);
    wire        low_reload = (state == IRSW_SHIFT_S) && !pin_sync && (low_timer >= REFR_CYC) && fifo_valid;
    // A start is raised only for a fresh sample, so stale reads see zeros.
    wire        start_go   = (state == IRSW_IDLE_S) && head.valid;

    assign fifo_take = start_go || low_reload;

    // Next-state selection.
    always_comb begin
        next_state = state;
        case (state)
            IRSW_IDLE_S: begin
                if (fifo_valid) next_state = IRSW_START_S;
            end
            IRSW_START_S: begin
                if (setup_done && pin_rise) next_state = IRSW_SHIFT_S;
            end
            IRSW_SHIFT_S: begin
                if (bit_cnt == LAST_BIT && !pin_sync) next_state = IRSW_END_S;
            end
            IRSW_END_S: begin
                if (end_done) next_state = IRSW_IDLE_S;
            end
            default: next_state = IRSW_IDLE_S;
        endcase
    end

    // Counters and shift register.
    always_ff @(posedge clk) begin
        if (rst) begin
            state     <= IRSW_IDLE_S;
            shift     <= irsw_pkg::IDLE_WORD;
            bit_cnt   <= 4'h0;
            timer     <= 32'h0;
            low_timer <= 32'h0;
            fresh     <= 1'b0;
        end else begin
            state     <= next_state;
            timer     <= timed_hold ? timer + 32'h1 : 32'h0;
            low_timer <= (state == IRSW_SHIFT_S && !pin_sync) ? low_timer + 32'h1 : 32'h0;
            if (start_go || low_reload) begin
                shift <= load_word;
                fresh <= 1'b1;
            end else if (state == IRSW_START_S && setup_done && pin_rise) begin
                bit_cnt <= 4'h1;
            end else if (state == IRSW_SHIFT_S && pin_rise) begin
                shift   <= {shift[13:0], 1'b0};
                bit_cnt <= bit_cnt + 4'h1;
            end else if (state == IRSW_END_S) begin
                shift   <= irsw_pkg::IDLE_WORD;
                bit_cnt <= 4'h0;
                fresh   <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive. The device drives its own phases and holds the wire low whenever idle, even under host pulses; during host high
    // phases the host's drive and ours agree, avoiding contention on data 1.
    logic next_out;
    logic next_oe;

    always_comb begin
        next_out = 1'b0;
        next_oe  = 1'b0;
        case (next_state)
            IRSW_IDLE_S: begin
                next_oe = !fresh;
            end
            IRSW_START_S: begin
                next_out = 1'b1;
                next_oe  = !(setup_done && !pin_sync);
            end
            IRSW_SHIFT_S: begin
                next_out = shift[14];
                next_oe  = pin_sync && !pin_rise;
            end
            IRSW_END_S: begin
                next_oe = 1'b1;
            end
            default: begin
                next_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            shared_link_pin_out <= 1'b0;
            shared_link_pin_oe  <= 1'b0;
            sample_ready        <= 1'b0;
            frame_busy          <= 1'b0;
        end else begin
            shared_link_pin_out <= next_out;
            shared_link_pin_oe  <= next_oe;
            sample_ready        <= fifo_in_ready;
            frame_busy          <= (next_state == IRSW_START_S) || (next_state == IRSW_SHIFT_S);
        end
    end

endmodule // irsw_link

// ---- hdl/irsw_pkg.sv ----
// Purpose: Shared constants and types for the single-wire infrared sensor read-out.
// Assumes: 125 MHz system clock.
// Notes:   All timing counts derive from times in their own units.
package irsw_pkg;

    localparam int unsigned CLK_MHZ           = 125;
    localparam int unsigned SAMPLE_BITS       = 15;
    localparam int unsigned DATA_BITS         = 14;
    // Least setup interval in microseconds after the start indication.
    localparam int unsigned START_SETUP_US    = 25;
    localparam int unsigned START_SETUP_CYC   = START_SETUP_US * CLK_MHZ;
    // Refresh interval in microseconds (3.7 ms typical).
    localparam int unsigned REFRESH_US        = 3700;
    localparam int unsigned REFRESH_CYC       = REFRESH_US * CLK_MHZ;
    // Quiet guard in microseconds after the last bit. It must outlast the host's
    // settling wait and its closing low pulse, or a queued start would spoil bit 0.
    localparam int unsigned END_GUARD_US      = 6;
    localparam int unsigned END_GUARD_CYC     = END_GUARD_US * CLK_MHZ;
    localparam int unsigned FIFO_DEPTH        = 16;
    localparam logic [14:0] IDLE_WORD         = 15'h0000;

    typedef enum logic [1:0] {
        IRSW_IDLE  = 2'b00,
        IRSW_START = 2'b01,
        IRSW_SHIFT = 2'b10,
        IRSW_END   = 2'b11
    } irsw_state_t;

    typedef struct packed {
        logic       valid;
        logic [13:0] value;
    } irsw_sample_t;

endpackage

// ---- hdl/irsw_fifo.sv ----
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: Single clock, synchronous active-high reset.
// Notes:   Read data come out of a register; full and empty are exact.
module irsw_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst,
    // Fill side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    wire              empty = (wr_ptr == rd_ptr);
    wire              full  = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    wire              push  = in_valid && !full;
    // The output register is refilled whenever it is empty or being taken.
    wire              pop   = !empty && (!out_valid || out_ready);

    assign in_ready = !full;

    ////////////////////////////////////////////////////////////////////////////
    // Storage and pointers.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) begin
                rd_ptr    <= rd_ptr + 1'b1;
                out_data  <= mem[rd_ptr[AW-1:0]];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end

endmodule // irsw_fifo

// ---- sim/irsw_link_properties.sv ----
// Purpose: Port checker for the single-wire link.
// Assumes: One clock; synchronous active-high reset.
// Notes:   Bound onto irsw_link after the module.
module irsw_link_chk (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        rst,
    // Link ports.
    input wire logic        sample_ready,
    input wire logic        shared_link_pin_in,
    input wire logic        shared_link_pin_out,
    input wire logic        shared_link_pin_oe,
    input wire logic        frame_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SETUP = irsw_pkg::START_SETUP_CYC;
    logic        drv_hi;
    logic        in_start;
    logic        pin_d;
    logic [15:0] hi_cnt;
    logic [4:0]  rises;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    // Device driving the wire high.
    assign drv_hi = shared_link_pin_oe && shared_link_pin_out;
    // Start flag, high-drive length and host rises; rises before the start drop are not host clocks.
    always_ff @(posedge clk) begin
        pin_d    <= shared_link_pin_in;
        hi_cnt   <= (rst || !drv_hi) ? 16'h0000 : hi_cnt + 16'h0001;
        in_start <= rst || !frame_busy || (in_start && (drv_hi || hi_cnt == 16'h0000));
        rises    <= (rst || !frame_busy) ? 5'h00 : rises + 5'(shared_link_pin_in && !pin_d && !in_start);
    end
    ////////////////////////////////////////////////////////////////////////////
    property p_reset_quiet;
        disable iff (1'b0) rst |=> !shared_link_pin_oe && !shared_link_pin_out && !frame_busy && !sample_ready;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
    property p_start_hold;
        $rose(drv_hi) && in_start |-> drv_hi [*8];
    endproperty
    a_start_hold: assert property (p_start_hold) else $error("start level not held");
    property p_start_busy;
        $rose(drv_hi) && in_start |-> frame_busy;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start without frame");
    property p_setup;
        in_start && frame_busy && !drv_hi && hi_cnt != 16'h0000 |-> hi_cnt >= SETUP;
    endproperty
    a_setup: assert property (p_setup) else $error("start level dropped before setup");
    property p_bit_resp;
        frame_busy && !in_start && shared_link_pin_in && !$past(shared_link_pin_in) |-> ##[1:6] shared_link_pin_oe;
    endproperty
    a_bit_resp: assert property (p_bit_resp) else $error("no bit after host edge");
    property p_bits_max;
        rises <= 5'd15;
    endproperty
    a_bits_max: assert property (p_bits_max) else $error("more than fifteen clocks");
    property p_bits_end;
        $fell(frame_busy) && !in_start |-> rises == 5'd15;
    endproperty
    a_bits_end: assert property (p_bits_end) else $error("frame ended off count");
    property p_idle_low;
        shared_link_pin_oe && !frame_busy |-> !shared_link_pin_out;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("idle drive not low");
    c_start: cover property ($rose(drv_hi) && in_start);
    c_full: cover property ($fell(sample_ready));
    c_end: cover property ($fell(frame_busy));
endmodule // irsw_link_chk

bind irsw_link irsw_link_chk irsw_link_chk_inst (.clk(clk), .rst(rst), .sample_ready(sample_ready),
    .shared_link_pin_in(shared_link_pin_in), .shared_link_pin_out(shared_link_pin_out),
    .shared_link_pin_oe(shared_link_pin_oe), .frame_busy(frame_busy));

// ---- sim/irsw_host_model.sv ----
// Purpose: Host end of the wire; clocks frames out of the device.
// Assumes: 80 ns link clock, free in phase of the system clock.
// Notes:   Settling is the 1 us floor; slow loads need more.
module irsw_host_model (
    // Wire level.
    input  wire logic wire_level,
    // Host drive.
    output logic      host_out,
    output logic      host_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial host_oe = 1'b0;
    initial host_out = 1'b0;
    ////////////////////////////////////////////////////////////////////////////
    // One frame read; the wait for start is bounded so a silent device cannot hang the run.
    task automatic read_word(input bit wait_start, output logic [14:0] word, output bit timed_out);
        int n;
        word = 15'h0000;
        n = 0;
        while (wait_start && wire_level !== 1'b1 && n < 2000) begin
            #8;
            n++;
        end
        timed_out = (n == 2000);
        if (wait_start) #25600;
        for (int i = 0; i < 15; i++) begin
            host_oe = 1'b1;
            host_out = 1'b0;
            #40;
            host_out = 1'b1;
            #40;
            host_oe = 1'b0;
            #1000;
            word = {word[13:0], wire_level};
        end
        host_oe = 1'b1;
        host_out = 1'b0;
        #40;
        host_oe = 1'b0;
    endtask
endmodule // irsw_host_model

// ---- sim/irsw_link_test.sv ----
// Purpose: Self-checking bench for the single-wire link.
// Assumes: 125 MHz clock; wire pulled low when nobody drives.
// Notes:   Fills the sample buffer, drains it, then reads past the data.
module irsw_link_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sample_valid = 1'b0;
    logic [13:0] sample_value = 14'h0000;
    logic        sample_ready;
    logic        pin;
    logic        dev_out;
    logic        dev_oe;
    logic        frame_busy;
    logic        host_out;
    logic        host_oe;
    int          mismatches = 0;
    int          check_count = 0;
    int          cycles = 0;
    ////////////////////////////////////////////////////////////////////////////
    // Wire: the host wins a clash so its low pulse ends each phase; released means low.
    assign pin = host_oe ? host_out : (dev_oe ? dev_out : 1'b0);
    irsw_link irsw_link_inst (.clk(clk), .rst(rst), .sample_valid(sample_valid), .sample_value(sample_value),
        .sample_ready(sample_ready), .shared_link_pin_in(pin), .shared_link_pin_out(dev_out),
        .shared_link_pin_oe(dev_oe), .frame_busy(frame_busy));
    irsw_host_model irsw_host_model_inst (.wire_level(pin), .host_out(host_out), .host_oe(host_oe));
    // Clock and run-time ceiling.
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 130000) begin
            mismatches++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [14:0] seen, input logic [14:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Offer one sample, then let the late ready flag catch up.
    task automatic push(input logic [13:0] v);
        sample_valid = 1'b1;
        sample_value = v;
        @(negedge clk);
        sample_valid = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task automatic read_expect(input bit wait_start, input logic [14:0] exp);
        logic [14:0] w;
        bit          to;
        irsw_host_model_inst.read_word(wait_start, w, to);
        @(negedge clk);
        check("start timeout", 15'(to), 15'h0000);
        check("frame word", w, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Fill until refused, then drain every word in order with a zero top bit.
    task automatic t_fill_drain();
        int n;
        n = 0;
        while (sample_ready === 1'b1 && n < 20) begin
            push(14'(n * 14'h1357));
            n++;
        end
        check("ready when full", 15'(sample_ready), 15'h0000);
        check("accepted at least depth", 15'(n >= 16), 15'h0001);
        for (int i = 0; i < n; i++) read_expect(1'b1, {1'b0, 14'(i * 14'h1357)});
        $display("test fill_drain done");
    endtask
    // With nothing queued the wire stays low and a read returns zeros; a new sample restarts.
    task automatic t_idle_zero();
        repeat (100) @(negedge clk);
        check("idle wire", 15'(pin), 15'h0000);
        check("idle busy", 15'(frame_busy), 15'h0000);
        read_expect(1'b0, 15'h0000);
        push(14'h3fff);
        read_expect(1'b1, 15'h3fff);
        $display("test idle_zero done");
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_fill_drain();
        t_idle_zero();
        report_and_stop();
    end
endmodule // irsw_link_test
